//--- logic/keypad_pkg.sv
// Overview of operation
// - sense capture holds the confirmed key's sense value in auto-scan, follows live sense in bypass; resets to all six bits set.
// - capture bits 5..0 mirror sense lines 5..0; a zero marks a low line.
// - timing register: debounce field bits 7..2, scan field bits 1..0, reset zero.
// - debounce is field times 4 ms; field zero selects 256 ms.
// - debounce applies to both key press and key release detection.
// - scan field sets time between key checks; code 1 is 1 ms, 2 is 2 ms.
// - control/status resets zero; bits 3..0 tick, auto-scan, key-found, irq enable.
// - auto-scan enable set means hardware scans; clear means software bypass mode.
// - key-found set on valid key or bypass falling edge; cleared on read.
// - key-found irq enable gates only the request; the flag still sets.
// - tick state bit reads the present level of the keypad tick.
package keypad_pkg;

  localparam int SENSE_W      = 6;
  localparam int REG_W        = 8;
  localparam int ADR_W        = 12;
  localparam int IDX_W        = 10;
  localparam int SYNC_STAGES  = 3;

  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SENSE_CAPTURE  = 10'h0D2;
  localparam logic [IDX_W-1:0] IDX_SCAN_TIMING    = 10'h0D3;
  localparam logic [IDX_W-1:0] IDX_CONTROL_STATUS = 10'h0D4;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS     = 10'h0D8;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR      = 10'h0D9;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE     = 10'h0DA;

  localparam logic [SENSE_W-1:0] SENSE_CAPTURE_RST  = 6'h3F;
  localparam logic [REG_W-1:0]   SCAN_TIMING_RST    = 8'h00;
  localparam logic [REG_W-1:0]   CONTROL_STATUS_RST = 8'h00;

  localparam int DB_MSB = 7;
  localparam int DB_LSB = 2;
  localparam int SC_MSB = 1;
  localparam int SC_LSB = 0;

  localparam int CS_TICK = 3;
  localparam int CS_AUTO = 2;
  localparam int CS_FLAG = 1;
  localparam int CS_IEN  = 0;

  localparam int IRQ_W           = 3;
  localparam int IRQ_KEY_FOUND   = 0;
  localparam int IRQ_INVALID_KEY = 1;
  localparam int IRQ_KEY_RELEASE = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // times in ms; the block counts rising edges of the 1 ms keypad tick
  localparam int TICK_PERIOD_MS   = 1;
  localparam int DEBOUNCE_STEP_MS = 4;
  localparam int DEBOUNCE_ZERO_MS = 256;
  localparam int SCAN_ZERO_MS     = 4;
  localparam int TIMER_W          = 9;
  localparam logic [TIMER_W-1:0] DEBOUNCE_STEP_TICKS = TIMER_W'(DEBOUNCE_STEP_MS / TICK_PERIOD_MS);
  localparam logic [TIMER_W-1:0] DEBOUNCE_ZERO_TICKS = TIMER_W'(DEBOUNCE_ZERO_MS / TICK_PERIOD_MS);
  localparam logic [TIMER_W-1:0] SCAN_ZERO_TICKS     = TIMER_W'(SCAN_ZERO_MS / TICK_PERIOD_MS);
  localparam logic [TIMER_W-1:0] TIMER_ZERO          = 9'h000;
  localparam logic [TIMER_W-1:0] TIMER_ONE           = 9'h001;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_PRESS_DB = 5'b00010,
    ST_SCAN     = 5'b00100,
    ST_WAIT_REL = 5'b01000,
    ST_REL_DB   = 5'b10000
  } scan_state_type;

endpackage

//--- logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // pin side
  input  wire logic [WIDTH-1:0] pin_in,
  // synchronised side
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_out <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          level_out[i] <= stage3_reg[i];
        end
      end
    end
  end

endmodule

//--- logic/keypad_sense_and_timing.sv
`timescale 1ns/1ps
module keypad_sense_and_timing #(
  parameter int SENSE_W = keypad_pkg::SENSE_W
) (
  // clock and reset
  input  wire logic                            core_clk_in,
  input  wire logic                            rstn_in,
  // wishbone classic slave
  input  wire logic                            wb_cyc_in,
  input  wire logic                            wb_stb_in,
  input  wire logic                            wb_we_in,
  input  wire logic [keypad_pkg::ADR_W-1:0]    wb_adr_in,
  input  wire logic [3:0]                      wb_sel_in,
  input  wire logic [31:0]                     wb_dat_in,
  output logic      [31:0]                     wb_dat_out,
  output logic                                 wb_ack_out,
  // keypad pins and tick
  input  wire logic [SENSE_W-1:0]              sense_in,
  input  wire logic                            tick_in,
  // status toward the rest of the scanner
  output logic                                 irq_out,
  output logic                                 auto_scan_enable_out,
  output logic                                 key_valid_out
);

  // reset release
  logic rst_ff1_reg;
  logic rst_n;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_ff1_reg <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_ff1_reg <= 1'b1;
      rst_n       <= rst_ff1_reg;
    end
  end

  // pin synchronisers
  logic [SENSE_W-1:0] sense_s;
  logic               tick_s;

  pin_sync #(
    .WIDTH     (SENSE_W),
    .RESET_VAL ({SENSE_W{1'b1}})
  ) u_sense_sync (
    .clk_in    (core_clk_in),
    .rst_n_in  (rst_n),
    .pin_in    (sense_in),
    .level_out (sense_s)
  );

  pin_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_tick_sync (
    .clk_in    (core_clk_in),
    .rst_n_in  (rst_n),
    .pin_in    (tick_in),
    .level_out (tick_s)
  );

  // helpers
  function automatic logic [keypad_pkg::TIMER_W-1:0] debounce_ticks(input logic [5:0] field);
    logic [keypad_pkg::TIMER_W-1:0] t;
    t = keypad_pkg::TIMER_ZERO;
    if (field == 6'h00) begin
      t = keypad_pkg::DEBOUNCE_ZERO_TICKS;
    end else begin
      t = keypad_pkg::TIMER_W'({3'h0, field} * keypad_pkg::DEBOUNCE_STEP_TICKS);
    end
    return t;
  endfunction

  function automatic logic [keypad_pkg::TIMER_W-1:0] scan_ticks(input logic [1:0] code);
    logic [keypad_pkg::TIMER_W-1:0] t;
    t = keypad_pkg::TIMER_ZERO;
    if (code == 2'h0) begin
      t = keypad_pkg::SCAN_ZERO_TICKS;
    end else begin
      t = {7'h00, code};
    end
    return t;
  endfunction

  function automatic logic single_low(input logic [SENSE_W-1:0] s);
    int n;
    n = 0;
    for (int i = 0; i < SENSE_W; i++) begin
      if (!s[i]) begin
        n++;
      end
    end
    return (n == 1);
  endfunction

  // registers
  logic [SENSE_W-1:0]               sense_capture_reg;
  logic [keypad_pkg::REG_W-1:0]     scan_timing_config_reg;
  logic                             auto_scan_enable_reg;
  logic                             key_found_flag_reg;
  logic                             key_found_irq_enable_reg;
  logic [keypad_pkg::IRQ_W-1:0]     irq_status_reg;
  logic [keypad_pkg::IRQ_W-1:0]     irq_enable_reg;
  logic                             tick_prev_reg;
  logic                             prev_all_high_reg;
  logic [keypad_pkg::TIMER_W-1:0]   timer_reg;
  keypad_pkg::scan_state_type       state_reg;

  logic [5:0] debounce_interval_field;
  logic [1:0] scan_interval_field;
  assign debounce_interval_field = scan_timing_config_reg[keypad_pkg::DB_MSB:keypad_pkg::DB_LSB];
  assign scan_interval_field     = scan_timing_config_reg[keypad_pkg::SC_MSB:keypad_pkg::SC_LSB];

  // bus decode
  logic                         take;
  logic                         wr;
  logic                         rd;
  logic [keypad_pkg::IDX_W-1:0] idx;
  assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr   = take && wb_we_in && wb_sel_in[0];
  assign rd   = take && !wb_we_in;
  assign idx  = wb_adr_in[keypad_pkg::ADR_W-1:2];

  logic tick_rise;
  logic all_high;
  logic timer_done;
  assign tick_rise  = tick_s && !tick_prev_reg;
  assign all_high   = &sense_s;
  assign timer_done = (timer_reg == keypad_pkg::TIMER_ZERO);

  // scan engine events
  logic valid_key;
  logic invalid_key;
  logic key_release;
  logic bypass_edge;
  logic scan_check;
  // gated by the enable: the engine only goes idle one edge after auto-scan is cleared
  assign scan_check  = auto_scan_enable_reg && (state_reg == keypad_pkg::ST_SCAN) && timer_done;
  assign valid_key   = scan_check && single_low(sense_s);
  assign invalid_key = scan_check && !single_low(sense_s) && !all_high;
  assign key_release = auto_scan_enable_reg && (state_reg == keypad_pkg::ST_REL_DB) && timer_done && all_high;
  assign bypass_edge = !auto_scan_enable_reg && prev_all_high_reg && !all_high;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_prev_reg     <= 1'b0;
      prev_all_high_reg <= 1'b1;
    end else begin
      tick_prev_reg     <= tick_s;
      prev_all_high_reg <= all_high;
    end
  end

  // timed scan: press debounce, scan check, release wait, release debounce
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= keypad_pkg::ST_IDLE;
      timer_reg <= keypad_pkg::TIMER_ZERO;
    end else if (!auto_scan_enable_reg) begin
      state_reg <= keypad_pkg::ST_IDLE;
      timer_reg <= keypad_pkg::TIMER_ZERO;
    end else begin
      if (tick_rise && !timer_done) begin
        timer_reg <= timer_reg - keypad_pkg::TIMER_ONE;
      end
      case (state_reg)
        keypad_pkg::ST_IDLE: begin
          if (!all_high) begin
            state_reg <= keypad_pkg::ST_PRESS_DB;
            timer_reg <= debounce_ticks(debounce_interval_field);
          end
        end
        keypad_pkg::ST_PRESS_DB: begin
          if (timer_done) begin
            if (all_high) begin
              state_reg <= keypad_pkg::ST_IDLE;
            end else begin
              state_reg <= keypad_pkg::ST_SCAN;
              timer_reg <= scan_ticks(scan_interval_field);
            end
          end
        end
        keypad_pkg::ST_SCAN: begin
          if (timer_done) begin
            state_reg <= all_high ? keypad_pkg::ST_IDLE : keypad_pkg::ST_WAIT_REL;
          end
        end
        keypad_pkg::ST_WAIT_REL: begin
          if (all_high) begin
            state_reg <= keypad_pkg::ST_REL_DB;
            timer_reg <= debounce_ticks(debounce_interval_field);
          end
        end
        keypad_pkg::ST_REL_DB: begin
          if (timer_done) begin
            if (all_high) begin
              state_reg <= keypad_pkg::ST_IDLE;
            end else begin
              // bounce: the debounce count starts again
              timer_reg <= debounce_ticks(debounce_interval_field);
            end
          end
        end
        default: begin
          state_reg <= keypad_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // sense capture: live in bypass so software can judge presses itself
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sense_capture_reg <= keypad_pkg::SENSE_CAPTURE_RST;
    end else if (!auto_scan_enable_reg) begin
      sense_capture_reg <= sense_s;
    end else if (valid_key) begin
      sense_capture_reg <= sense_s;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scan_timing_config_reg <= keypad_pkg::SCAN_TIMING_RST;
    end else if (wr && idx == keypad_pkg::IDX_SCAN_TIMING) begin
      scan_timing_config_reg <= wb_dat_in[keypad_pkg::REG_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      auto_scan_enable_reg     <= keypad_pkg::CONTROL_STATUS_RST[keypad_pkg::CS_AUTO];
      key_found_irq_enable_reg <= keypad_pkg::CONTROL_STATUS_RST[keypad_pkg::CS_IEN];
    end else if (wr && idx == keypad_pkg::IDX_CONTROL_STATUS) begin
      auto_scan_enable_reg     <= wb_dat_in[keypad_pkg::CS_AUTO];
      key_found_irq_enable_reg <= wb_dat_in[keypad_pkg::CS_IEN];
    end
  end

  // set wins over the clear-on-read in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      key_found_flag_reg <= keypad_pkg::CONTROL_STATUS_RST[keypad_pkg::CS_FLAG];
    end else if (valid_key || bypass_edge) begin
      key_found_flag_reg <= 1'b1;
    end else if (rd && idx == keypad_pkg::IDX_CONTROL_STATUS) begin
      key_found_flag_reg <= 1'b0;
    end
  end

  // sticky event status, write-one-to-clear, set wins
  logic [keypad_pkg::IRQ_W-1:0] irq_set;
  logic [keypad_pkg::IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_set = keypad_pkg::IRQ_RST;
    irq_set[keypad_pkg::IRQ_KEY_FOUND]   = valid_key || bypass_edge;
    irq_set[keypad_pkg::IRQ_INVALID_KEY] = invalid_key;
    irq_set[keypad_pkg::IRQ_KEY_RELEASE] = key_release;
    irq_clr = keypad_pkg::IRQ_RST;
    if (wr && idx == keypad_pkg::IDX_IRQ_CLEAR) begin
      irq_clr = wb_dat_in[keypad_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= keypad_pkg::IRQ_RST;
    end else begin
      irq_status_reg <= irq_set | (irq_status_reg & ~irq_clr);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_reg <= keypad_pkg::IRQ_RST;
    end else if (wr && idx == keypad_pkg::IDX_IRQ_ENABLE) begin
      irq_enable_reg <= wb_dat_in[keypad_pkg::IRQ_W-1:0];
    end
  end

  // the enable only gates the request, never the flag itself
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (key_found_flag_reg && key_found_irq_enable_reg) || |(irq_status_reg & irq_enable_reg);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      auto_scan_enable_out <= 1'b0;
      key_valid_out        <= 1'b0;
    end else begin
      auto_scan_enable_out <= auto_scan_enable_reg;
      key_valid_out        <= valid_key;
    end
  end

  // read mux; unmapped and write-only addresses read zero
  logic [keypad_pkg::REG_W-1:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    case (idx)
      keypad_pkg::IDX_SENSE_CAPTURE: begin
        rd_data[SENSE_W-1:0] = sense_capture_reg;
      end
      keypad_pkg::IDX_SCAN_TIMING: begin
        rd_data = scan_timing_config_reg;
      end
      keypad_pkg::IDX_CONTROL_STATUS: begin
        rd_data[keypad_pkg::CS_TICK] = tick_s;
        rd_data[keypad_pkg::CS_AUTO] = auto_scan_enable_reg;
        rd_data[keypad_pkg::CS_FLAG] = key_found_flag_reg;
        rd_data[keypad_pkg::CS_IEN]  = key_found_irq_enable_reg;
      end
      keypad_pkg::IDX_IRQ_STATUS: begin
        rd_data[keypad_pkg::IRQ_W-1:0] = irq_status_reg;
      end
      keypad_pkg::IDX_IRQ_ENABLE: begin
        rd_data[keypad_pkg::IRQ_W-1:0] = irq_enable_reg;
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // every access is acked one cycle after it is taken
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= take;
      if (rd) begin
        wb_dat_out <= {24'h000000, rd_data};
      end
    end
  end

endmodule

//--- test/keypad_matrix_model.sv
`timescale 1ns/1ps
module keypad_matrix_model (
  // pressed rows from the bench
  input  wire logic [5:0] press_in,
  // sense lines, pulled up when open
  output logic      [5:0] sense_out
);
  // open switches read high through the pull-ups, never a stale level
  assign sense_out = ~press_in;
endmodule

//--- test/keypad_sense_and_timing_chk.sv
`timescale 1ns/1ps
module keypad_sense_and_timing_chk #(
  parameter int SENSE_W = keypad_pkg::SENSE_W
) (
  input wire logic                         core_clk_in,
  input wire logic                         rstn_in,
  input wire logic                         wb_cyc_in,
  input wire logic                         wb_stb_in,
  input wire logic                         wb_we_in,
  input wire logic [keypad_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [3:0]                   wb_sel_in,
  input wire logic [31:0]                  wb_dat_in,
  input wire logic [31:0]                  wb_dat_out,
  input wire logic                         wb_ack_out,
  input wire logic [SENSE_W-1:0]           sense_in,
  input wire logic                         tick_in,
  input wire logic                         irq_out,
  input wire logic                         auto_scan_enable_out,
  input wire logic                         key_valid_out
);
  logic       take;
  logic       rd_q;
  logic [9:0] idx_q;
  logic [7:0] timing_q;
  assign take = wb_cyc_in & wb_stb_in & !wb_ack_out;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_q  <= 1'b0;
      idx_q <= '0;
    end else if (take) begin
      rd_q  <= !wb_we_in;
      idx_q <= wb_adr_in[11:2];
    end
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timing_q <= 8'h00;
    end else if (take && wb_we_in && wb_sel_in[0] && wb_adr_in[11:2] == keypad_pkg::IDX_SCAN_TIMING) begin
      timing_q <= wb_dat_in[7:0];
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  ack_answer_a: assert property (take |=> wb_ack_out) else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  upper_zero_a: assert property (wb_ack_out && rd_q |-> wb_dat_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  sense_unused_a: assert property (wb_ack_out && rd_q && idx_q == keypad_pkg::IDX_SENSE_CAPTURE
    |-> wb_dat_out[7:6] == 2'h0) else $error("capture bits 7:6 set");
  status_unused_a: assert property (wb_ack_out && rd_q && idx_q == keypad_pkg::IDX_CONTROL_STATUS
    |-> wb_dat_out[7:4] == 4'h0) else $error("status bits 7:4 set");
  timing_rw_a: assert property (wb_ack_out && rd_q && idx_q == keypad_pkg::IDX_SCAN_TIMING
    |-> wb_dat_out[7:0] == timing_q) else $error("timing read differs from write");
  unmapped_zero_a: assert property (wb_ack_out && rd_q && !(idx_q inside {10'h0D2, 10'h0D3, 10'h0D4, 10'h0D8, 10'h0DA})
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  auto_copy_a: assert property (take && wb_we_in && wb_sel_in[0] && wb_adr_in[11:2] == keypad_pkg::IDX_CONTROL_STATUS
    |-> ##2 auto_scan_enable_out == $past(wb_dat_in[2], 2)) else $error("auto scan output wrong");
  valid_pulse_a: assert property (key_valid_out |=> !key_valid_out) else $error("valid key pulse too long");
  valid_auto_a: assert property (key_valid_out |-> auto_scan_enable_out) else $error("valid key in bypass");
  cover property (key_valid_out);
  cover property ($rose(irq_out));
  cover property (wb_ack_out && rd_q && idx_q == keypad_pkg::IDX_SENSE_CAPTURE);
endmodule

bind keypad_sense_and_timing keypad_sense_and_timing_chk #(.SENSE_W(SENSE_W)) chk (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .sense_in(sense_in), .tick_in(tick_in),
  .irq_out(irq_out), .auto_scan_enable_out(auto_scan_enable_out), .key_valid_out(key_valid_out));

//--- test/test_keypad_sense_and_timing.sv
`timescale 1ns/1ps
module test_keypad_sense_and_timing;
  localparam logic [9:0] CAP = keypad_pkg::IDX_SENSE_CAPTURE;
  localparam logic [9:0] TIM = keypad_pkg::IDX_SCAN_TIMING;
  localparam logic [9:0] CST = keypad_pkg::IDX_CONTROL_STATUS;
  localparam logic [9:0] IST = keypad_pkg::IDX_IRQ_STATUS;
  localparam logic [9:0] ICL = keypad_pkg::IDX_IRQ_CLEAR;
  localparam logic [9:0] IEN = keypad_pkg::IDX_IRQ_ENABLE;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  sel;
  logic [11:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [5:0]  press;
  logic [5:0]  sense;
  logic        tick;
  logic        irq;
  logic        auto_en;
  logic        kvalid;
  int          valid_cnt = 0;
  int          valid_base;
  logic [31:0] rd;
  int          error_cnt;
  int          check_count;

  keypad_matrix_model pad (.press_in(press), .sense_out(sense));
  keypad_sense_and_timing DUT (.core_clk_in(clk), .rstn_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .sense_in(sense), .tick_in(tick), .irq_out(irq),
    .auto_scan_enable_out(auto_en), .key_valid_out(kvalid));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) if (kvalid === 1'b1) valid_cnt <= valid_cnt + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'h1;
    adr  <= {idx, 2'h0};
    wdat <= {24'h0, d};
    n = 0;
    // no wait limit here: only the watchdog ends a stuck access
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    rd = rdat;
    check(n, 32'h2);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      repeat (8) @(posedge clk);
      tick <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  // also notes the valid-key count so each press is judged alone
  task automatic pressw(input logic [5:0] m);
    @(posedge clk);
    press      <= m;
    valid_base = valid_cnt;
    repeat (12) @(posedge clk);
  endtask

  task automatic t_reset;
    rdc(CAP, 8'h3F);
    rdc(TIM, 8'h00);
    rdc(CST, 8'h00);
    rdc(IST, 8'h00);
    rdc(IEN, 8'h00);
  endtask

  task automatic t_regs;
    wb(1'b1, TIM, 8'hA6);
    rdc(TIM, 8'hA6);
    wb(1'b1, CAP, 8'h00);
    rdc(CAP, 8'h3F);
    wb(1'b1, CST, 8'hFB);
    rdc(CST, 8'h01);
    @(posedge clk);
    tick <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(CST, 8'h09);
    tick <= 1'b0;
    rdc(10'h0FF, 8'h00);
    rdc(ICL, 8'h00);
  endtask

  task automatic t_bypass;
    pressw(6'h01);
    check(32'(irq), 32'h1);
    rdc(CAP, 8'h3E);
    rdc(CST, 8'h03);
    rdc(CST, 8'h01);
    check(32'(irq), 32'h0);
    pressw(6'h00);
    wb(1'b1, CST, 8'h00);
    pressw(6'h20);
    rdc(CAP, 8'h1F);
    check(32'(irq), 32'h0);
    rdc(CST, 8'h02);
    rdc(IST, 8'h01);
    wb(1'b1, IEN, 8'h01);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h1);
    wb(1'b1, ICL, 8'h01);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    rdc(IST, 8'h00);
    wb(1'b1, IEN, 8'h00);
    pressw(6'h00);
  endtask

  // single key per timing code; zero codes pick the longest settings
  task automatic t_timing;
    logic [7:0] cfg [4];
    int d;
    int s;
    int n;
    cfg = '{8'h05, 8'h06, 8'h07, 8'h00};
    wb(1'b1, CST, 8'h04);
    @(posedge clk);
    check(32'(auto_en), 32'h1);
    foreach (cfg[i]) begin
      d = (cfg[i][7:2] == 6'h00) ? 256 : 4 * int'(cfg[i][7:2]);
      s = (cfg[i][1:0] == 2'h0) ? 4 : int'(cfg[i][1:0]);
      wb(1'b1, TIM, cfg[i]);
      pressw(6'h04);
      n = 0;
      while (valid_cnt == valid_base && n < d + s + 3) begin
        ticks(1);
        n++;
      end
      check(32'(n >= d + s && n <= d + s + 1), 32'h1);
      rdc(CAP, 8'h3B);
      pressw(6'h00);
      ticks(d - 1);
      rdc(IST, 8'h01);
      ticks(2);
      rdc(IST, 8'h05);
      wb(1'b1, ICL, 8'h07);
    end
  endtask

  task automatic t_multi;
    wb(1'b1, TIM, 8'h05);
    pressw(6'h03);
    ticks(7);
    check(32'(valid_cnt - valid_base), 32'h0);
    rdc(IST, 8'h02);
    pressw(6'h00);
    ticks(6);
    wb(1'b1, ICL, 8'h07);
    wb(1'b1, CST, 8'h00);
    @(posedge clk);
    check(32'(auto_en), 32'h0);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 12'h000;
    wdat = 32'h0;
    press = 6'h00;
    tick = 1'b0;
    valid_base = 0;
    error_cnt = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_regs();
    t_bypass();
    t_timing();
    t_multi();
    final_report();
  end
endmodule
